/* brap_top.sv */
// Board reset, abort and front-panel status logic.
// Assumes switch and status inputs already synchronous to clk_i;
// low-active pins keep an _n in their name.
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// R1: Reset push switch resets every on-board device.
// R2: As system controller, reset switch also asserts backplane system reset.
// R3: Backplane reset from switch, power-up, watchdog or software bit.
// R4: Backplane system reset held at least 200 ms once asserted.
// R5: Local reset works whether or not board is system controller.
// R6: Local reset from switch, power-up, watchdog, backplane reset, software.
// R7: Software local-reset bit holds the board in reset while set.
// R8: Abort interrupt raised only while software enables it.
// R9: Abort comes from switch press or software, same event.
// R10: Abort drives the interrupt line and the status port bit.
// R11: Abort is edge triggered and debounced to one event.
// R12: Checkstop lamp lights on processor halt, clears on reset.
// R13: Board fault lamp follows the board fault signal.
// R14: CPU lamp lights while data bus busy is active.
// R15: PCI lamp lights while initiator ready is active.
// R16: System controller lamp lights while in system controller role.
// R17: During reset all lamps light as a lamp test.
// R18: Jumper selects reset vector from 64-bit bank A or 16-bit bank B.
// R19: Abort switch must be stable a few milliseconds before accepted.
module brap_top #(
   parameter int SYSRST_HOLD = brap_pkg::SYSRST_HOLD_CYC,
   parameter int ABORT_STABLE = brap_pkg::ABORT_STABLE_CYC
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   output logic irq_o,
   input wire logic reset_push_switch_n_i,
   input wire logic abort_push_switch_n_i,
   input wire logic watchdog_expired_i,
   input wire logic sysctl_role_i,
   input wire logic sysreset_n_i,
   input wire logic cpu_halt_i,
   input wire logic board_fault_n_i,
   input wire logic data_bus_busy_n_i,
   input wire logic pci_irdy_n_i,
   input wire logic power_ok_i,
   input wire logic reset_vector_select_jumper_i,
   output logic sysreset_n_o,
   output logic sysreset_oe_n_o,
   output logic local_reset_n_o,
   output logic abort_irq_n_o,
   output logic abort_status_port_bit_o,
   output logic vector_bank_b_o,
   output brap_pkg::brap_leds_t leds_o
);

   // Refuse counts that the counters cannot serve
   if (SYSRST_HOLD < 1 || ABORT_STABLE < 1) begin : g_bad_count
      $error("brap_top: counts must be at least one cycle");
   end

   logic [7:0] miscellaneous_control_reg;
   logic [7:0] irq_stat;
   logic [7:0] irq_mask;
   logic [10:0] pwrup_cnt;
   logic pwrup_active;
   logic [31:0] hold_cnt;
   brap_pkg::brap_sr_state_t sr_state;
   logic sys_src;
   logic loc_src;
   logic sw_abort_pulse;
   logic [31:0] stable_cnt;
   logic abort_filt;
   logic abort_raw_q;
   logic abort_press;
   logic abort_event;
   logic in_reset;
   logic sysrst_in_q;
   logic checkstop;
   logic [7:0] events;
   logic [7:0] next_stat;

   // Power-up reset stretch after the async release
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pwrup_cnt <= 11'h000;
      end else if (pwrup_active) begin
         pwrup_cnt <= pwrup_cnt + 11'h001;
      end
   end
   assign pwrup_active = (pwrup_cnt < 11'(brap_pkg::PWRUP_CYC));

   // Backplane reset sources, only meaningful as system controller
   assign sys_src = sysctl_role_i &                                    // R2
      (!reset_push_switch_n_i | pwrup_active | watchdog_expired_i |    // R3
       miscellaneous_control_reg[brap_pkg::CTL_SYSRST]);
   // Local reset sources, independent of role
   assign loc_src = !reset_push_switch_n_i | pwrup_active |            // R6
      watchdog_expired_i | !sysreset_n_i |                             // R5
      miscellaneous_control_reg[brap_pkg::CTL_LOCRST];                 // R7

   // Backplane reset stretcher; the hold counter restarts while a source
   // stays active, so release is at least the hold after the last one
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sr_state <= brap_pkg::BRAP_SR_IDLE;
         hold_cnt <= 32'h0;
      end else begin
         unique case (sr_state)
            brap_pkg::BRAP_SR_IDLE: begin
               if (sys_src) begin
                  sr_state <= brap_pkg::BRAP_SR_HOLD;
                  hold_cnt <= 32'h0;
               end
            end
            brap_pkg::BRAP_SR_HOLD: begin
               if (sys_src) begin
                  hold_cnt <= 32'h0;
               end else if (hold_cnt >= 32'(SYSRST_HOLD - 1)) begin
                  sr_state <= brap_pkg::BRAP_SR_IDLE;                  // R4
               end else begin
                  hold_cnt <= hold_cnt + 32'h1;
               end
            end
            default: sr_state <= brap_pkg::BRAP_SR_IDLE;
         endcase
      end
   end

   // Reset outputs; open-drain backplane line, enable low drives
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sysreset_n_o <= 1'b0;
         sysreset_oe_n_o <= 1'b1;
         local_reset_n_o <= 1'b0;
      end else begin
         sysreset_n_o <= 1'b0;
         sysreset_oe_n_o <= !(sys_src |                                // R3
            (sr_state == brap_pkg::BRAP_SR_HOLD));                     // R4
         local_reset_n_o <= !loc_src;                                  // R1
      end
   end
   assign in_reset = loc_src;

   // Debounce: accept a new level only after it held ABORT_STABLE cycles
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         abort_raw_q <= 1'b0;
         stable_cnt <= 32'h0;
         abort_filt <= 1'b0;
      end else begin
         abort_raw_q <= !abort_push_switch_n_i;
         if (abort_raw_q == abort_filt) begin
            stable_cnt <= 32'h0;
         end else if (stable_cnt >= 32'(ABORT_STABLE - 1)) begin
            abort_filt <= abort_raw_q;                                 // R19
            stable_cnt <= 32'h0;
         end else begin
            stable_cnt <= stable_cnt + 32'h1;
         end
      end
   end
   // Edge of the filtered level, not the level itself
   assign abort_press = (abort_raw_q == abort_filt) ? 1'b0 :
      (abort_raw_q && stable_cnt >= 32'(ABORT_STABLE - 1));            // R11
   assign sw_abort_pulse = wr_i && addr_i == brap_pkg::ADDR_CTRL &&
      wdata_i[brap_pkg::CTL_SW_ABORT];
   assign abort_event = abort_press | sw_abort_pulse;                  // R9

   // Abort interrupt gated by the enable bit; the status port bit is not
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         abort_irq_n_o <= 1'b1;
         abort_status_port_bit_o <= 1'b0;
      end else begin
         if (!miscellaneous_control_reg[brap_pkg::CTL_ABORT_EN]) begin
            abort_irq_n_o <= 1'b1;                                     // R8
         end else if (abort_event) begin
            abort_irq_n_o <= 1'b0;                                     // R10
         end else if (wr_i && addr_i == brap_pkg::ADDR_IRQ_STAT &&
                      wdata_i[brap_pkg::EV_ABORT]) begin
            abort_irq_n_o <= 1'b1;
         end
         abort_status_port_bit_o <= abort_filt | sw_abort_pulse;      // R10
      end
   end

   // Checkstop latch; cleared only by a board reset
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         checkstop <= 1'b0;
      end else if (in_reset) begin
         checkstop <= 1'b0;                                            // R12
      end else if (cpu_halt_i) begin
         checkstop <= 1'b1;                                            // R12
      end
   end

   // Lamps; lamp test overrides every source while in reset
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         leds_o <= '1;
      end else if (in_reset) begin
         leds_o <= '1;                                                 // R17
      end else begin
         leds_o.checkstop <= checkstop;
         leds_o.board_fault <= !board_fault_n_i;                       // R13
         leds_o.cpu_activity <= !data_bus_busy_n_i;                    // R14
         leds_o.pci_activity <= !pci_irdy_n_i;                         // R15
         leds_o.power_ok <= power_ok_i;
         leds_o.sysctl_role <= sysctl_role_i;                          // R16
      end
   end

   // Vector bank: jumper high selects 16-bit bank B
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         vector_bank_b_o <= 1'b0;
      end else begin
         vector_bank_b_o <= reset_vector_select_jumper_i;              // R18
      end
   end

   // Control and mask registers; software abort bit is self clearing
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         miscellaneous_control_reg <= brap_pkg::CTRL_RESET;
         irq_mask <= brap_pkg::MASK_RESET;
      end else if (wr_i) begin
         if (addr_i == brap_pkg::ADDR_CTRL) begin
            miscellaneous_control_reg <= wdata_i &
               ~(8'h01 << brap_pkg::CTL_SW_ABORT);
         end
         if (addr_i == brap_pkg::ADDR_IRQ_MASK) begin
            irq_mask <= wdata_i;
         end
      end
   end

   // Sticky events; a set in the clearing cycle wins
   always_comb begin
      events = 8'h00;
      events[brap_pkg::EV_ABORT] = abort_event &
         miscellaneous_control_reg[brap_pkg::CTL_ABORT_EN];
      events[brap_pkg::EV_SYSRST_IN] = !sysreset_n_i & sysrst_in_q;
      events[brap_pkg::EV_WDOG] = watchdog_expired_i;
      next_stat = irq_stat;
      if (wr_i && addr_i == brap_pkg::ADDR_IRQ_STAT) begin
         next_stat = next_stat & ~wdata_i;
      end
      next_stat = next_stat | events;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_stat <= 8'h00;
         sysrst_in_q <= 1'b1;
         irq_o <= 1'b0;
      end else begin
         irq_stat <= next_stat;
         sysrst_in_q <= sysreset_n_i;
         irq_o <= |(next_stat & irq_mask);
      end
   end

   // Read port, data one cycle after the strobe
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= 8'h00;
      end else if (rd_i) begin
         unique case (addr_i)
            brap_pkg::ADDR_CTRL: rdata_o <= miscellaneous_control_reg;
            brap_pkg::ADDR_STATUS: rdata_o <= {2'h0, vector_bank_b_o,
               abort_filt, checkstop, sysctl_role_i,
               !sysreset_oe_n_o, !local_reset_n_o};
            brap_pkg::ADDR_IRQ_STAT: rdata_o <= irq_stat;
            brap_pkg::ADDR_IRQ_MASK: rdata_o <= irq_mask;
            default: rdata_o <= 8'h00;
         endcase
      end else begin
         rdata_o <= 8'h00;
      end
   end

   // Checks; the run counter lets the hold check see the whole drive,
   // since a short fixed repetition cannot span the full hold
   logic [31:0] oe_low_run;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         oe_low_run <= 32'h0;
      end else if (sysreset_oe_n_o) begin
         oe_low_run <= 32'h0;
      end else begin
         oe_low_run <= oe_low_run + 32'h1;
      end
   end

   chk_sysrst_hold: assert property (@(posedge clk_i) // R4
      disable iff (!rst_n_i)
      $rose(!sysreset_oe_n_o) |-> !sysreset_oe_n_o [*8])
      else $error("backplane reset released too early");
   chk_sysrst_span: assert property (@(posedge clk_i) // R4
      disable iff (!rst_n_i)
      !sysreset_oe_n_o ##1 sysreset_oe_n_o
      |-> oe_low_run >= 32'(SYSRST_HOLD))
      else $error("backplane reset drive shorter than the hold");
   chk_switch_sysrst: assert property (@(posedge clk_i) // R2
      disable iff (!rst_n_i)
      !reset_push_switch_n_i && sysctl_role_i |=> !sysreset_oe_n_o)
      else $error("switch did not drive backplane reset");
   chk_no_role_drive: assert property (@(posedge clk_i) // R2
      disable iff (!rst_n_i)
      !sysctl_role_i && sr_state == brap_pkg::BRAP_SR_IDLE
      |=> sysreset_oe_n_o)
      else $error("backplane reset driven outside controller role");
   chk_local_src: assert property (@(posedge clk_i) // R6
      disable iff (!rst_n_i)
      !sysreset_n_i || !reset_push_switch_n_i |=> !local_reset_n_o)
      else $error("local reset missed a source");
   chk_pwrup_local: assert property (@(posedge clk_i) // R6
      disable iff (!rst_n_i)
      pwrup_active |=> !local_reset_n_o)
      else $error("power-up stretch did not hold local reset");
   chk_sw_hold: assert property (@(posedge clk_i) // R7
      disable iff (!rst_n_i)
      miscellaneous_control_reg[brap_pkg::CTL_LOCRST]
      |=> !local_reset_n_o)
      else $error("software hold did not keep reset");
   chk_abort_gate: assert property (@(posedge clk_i) // R8
      disable iff (!rst_n_i)
      !miscellaneous_control_reg[brap_pkg::CTL_ABORT_EN]
      |=> abort_irq_n_o)
      else $error("abort interrupt while disabled");
   chk_sw_abort: assert property (@(posedge clk_i) // R9
      disable iff (!rst_n_i)
      sw_abort_pulse && miscellaneous_control_reg[brap_pkg::CTL_ABORT_EN]
      |=> !abort_irq_n_o && abort_status_port_bit_o)
      else $error("software abort lost");
   chk_lamp_test: assert property (@(posedge clk_i) // R17
      disable iff (!rst_n_i)
      in_reset |=> leds_o == '1)
      else $error("lamp test not lit");
   chk_fault_lamp: assert property (@(posedge clk_i) // R13
      disable iff (!rst_n_i)
      !in_reset && !board_fault_n_i |=> leds_o.board_fault)
      else $error("fault lamp dark");
   chk_checkstop_clr: assert property (@(posedge clk_i) // R12
      disable iff (!rst_n_i)
      in_reset ##1 !in_reset && !cpu_halt_i |=> !leds_o.checkstop)
      else $error("checkstop survived reset");
endmodule

`default_nettype wire

/* brap_pkg.sv */
// Package for the board reset, abort and panel block.
// Assumes a single 200 MHz clock domain; no imports anywhere.
package brap_pkg;
   // Clock rate
   localparam int CLK_HZ = 200000000;
   localparam int CLK_PERIOD_NS = 5;
   // Least hold of the backplane system reset
   localparam int SYSRST_HOLD_MS = 200;
   localparam longint SYSRST_HOLD_CYC_L =
      (longint'(SYSRST_HOLD_MS) * CLK_HZ + 999) / 1000;
   localparam int SYSRST_HOLD_CYC = int'(SYSRST_HOLD_CYC_L);
   // Abort switch stable interval before an edge is accepted
   localparam int ABORT_STABLE_MS = 4;
   localparam int ABORT_STABLE_CYC =
      int'((longint'(ABORT_STABLE_MS) * CLK_HZ + 999) / 1000);
   // Power-up reset stretch, in cycles
   localparam int PWRUP_CYC = 1024;
   // Register map
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h1;
   localparam logic [3:0] ADDR_IRQ_STAT = 4'h2;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;
   // Control register bit positions
   localparam int CTL_SYSRST = 0;
   localparam int CTL_LOCRST = 1;
   localparam int CTL_ABORT_EN = 2;
   localparam int CTL_SW_ABORT = 3;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // Interrupt status bit positions
   localparam int EV_ABORT = 0;
   localparam int EV_SYSRST_IN = 1;
   localparam int EV_WDOG = 2;
   localparam logic [7:0] MASK_RESET = 8'h00;

   typedef enum logic [1:0] {
      BRAP_SR_IDLE = 2'b00,
      BRAP_SR_HOLD = 2'b01
   } brap_sr_state_t;

   // Panel indicator bundle
   typedef struct packed {
      logic checkstop;
      logic board_fault;
      logic cpu_activity;
      logic pci_activity;
      logic power_ok;
      logic sysctl_role;
   } brap_leds_t;
endpackage

/* brap_partner.sv */
// Backplane and processor-bus model on the far side of the panel block.
// Assumes one clock; the backplane reset line has a pull-up.
`timescale 1ns/1ps
`default_nettype none
module brap_partner #(
   parameter int HOLD = 30
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic sysreset_oe_n_i,
   input wire logic sysreset_drv_i,
   input wire logic req_i,
   output logic sysreset_n_o,
   output logic data_bus_busy_n_o,
   output logic pci_irdy_n_o
);
   int cnt;
   logic [15:0] act;
   // Pulled up unless the block or the other controller pulls it low
   assign sysreset_n_o = (sysreset_oe_n_i || sysreset_drv_i) && cnt == 0;
   // Other controller keeps its reset for a whole hold span
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         cnt <= 0;
      else if (req_i)
         cnt <= HOLD;
      else if (cnt != 0)
         cnt <= cnt - 1;
   end
   // Busy strobes follow a pseudo-random LFSR sequence, so stuck lamps show up
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         act <= 16'hace1;
      else
         act <= {act[14:0], act[15] ^ act[13] ^ act[12] ^ act[10]};
   end
   assign data_bus_busy_n_o = act[0];
   assign pci_irdy_n_o = act[5];
endmodule
`default_nettype wire

/* brap_tb.sv */
// Self-checking bench for the board reset, abort and panel block.
// Assumes brap_pkg, brap_top and brap_partner are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int HOLD = 20;
   localparam int STAB = 4;
   localparam int PHOLD = 30;
   localparam logic [3:0] A_CTL = brap_pkg::ADDR_CTRL;
   localparam logic [3:0] A_ST = brap_pkg::ADDR_IRQ_STAT;
   localparam logic [3:0] A_MSK = brap_pkg::ADDR_IRQ_MASK;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0, rd = 1'b0, rst_sw_n = 1'b1, abt_sw_n = 1'b1;
   logic wdog = 1'b0, role = 1'b1, halt = 1'b0, bf_n = 1'b1, pwr = 1'b1;
   logic jmp = 1'b0, bp_req = 1'b0;
   logic [7:0] rdata;
   logic irq, sr_n, oe_n, lrst_n, abt_n, abt_pb, bank_b, bp_n, dbb_n;
   logic irdy_n, rd_seen, bank, lr_ok;
   logic [4:0] lamps;
   brap_pkg::brap_leds_t leds;
   logic [7:0] rd_q[$];
   logic [31:0] seed = 32'h2cfb;
   int err_total = 0;
   int compares = 0;

   brap_top #(.SYSRST_HOLD(HOLD), .ABORT_STABLE(STAB)) brap_top_i (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_o(irq),
      .reset_push_switch_n_i(rst_sw_n), .abort_push_switch_n_i(abt_sw_n),
      .watchdog_expired_i(wdog), .sysctl_role_i(role), .sysreset_n_i(bp_n),
      .cpu_halt_i(halt), .board_fault_n_i(bf_n), .data_bus_busy_n_i(dbb_n),
      .pci_irdy_n_i(irdy_n), .power_ok_i(pwr),
      .reset_vector_select_jumper_i(jmp), .sysreset_n_o(sr_n),
      .sysreset_oe_n_o(oe_n), .local_reset_n_o(lrst_n),
      .abort_irq_n_o(abt_n), .abort_status_port_bit_o(abt_pb),
      .vector_bank_b_o(bank_b), .leds_o(leds));
   brap_partner #(.HOLD(PHOLD)) brap_partner_i (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .sysreset_oe_n_i(oe_n),
      .sysreset_drv_i(sr_n), .req_i(bp_req), .sysreset_n_o(bp_n),
      .data_bus_busy_n_o(dbb_n), .pci_irdy_n_o(irdy_n));

   // 200 MHz clock
   always #2.5 clk_i = ~clk_i;

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic pin(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %0t pin got %b exp %b", $time, got, exp);
      end
   endtask
   task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %0t read got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk_i);
      wr <= 1'b0;
   endtask
   // Expected data is queued here and taken off by the monitor
   task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk_i);
      rd <= 1'b1;
      addr <= a;
      rd_q.push_back(e);
      @(posedge clk_i);
      rd <= 1'b0;
   endtask
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic give_verdict();
      $display("Errors %0d in %0d compares", err_total, compares);
      if (err_total == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Monitor: inputs seen at the edge, registered results half a cycle on
   always @(posedge clk_i) begin
      rd_seen = rd;
      lamps = {~bf_n, ~dbb_n, ~irdy_n, pwr, role};
      bank = jmp;
      lr_ok = rst_n_i && lrst_n === 1'b1;
      @(negedge clk_i);
      if (rd_seen)
         chk_rd(rdata, rd_q.pop_front());
      // Lamp test owns the lamps around any reset edge
      if (lr_ok && lrst_n === 1'b1) begin
         pin(leds[4:0] === lamps, 1'b1);
         pin(bank_b, bank);
      end
   end

   // Hang guard, far beyond the some 1400 cycles of the run
   initial begin
      #(20000 * 5);
      err_total++;
      give_verdict();
   end

   initial begin
      cyc(2);
      pin(lrst_n, 1'b0);
      pin(leds === 6'h3f, 1'b1);
      pin(oe_n, 1'b1);
      cyc(2);
      rst_n_i <= 1'b1;
      // Power-up stretch, then the backplane hold on top of it
      cyc(10);
      pin(lrst_n, 1'b0);
      pin(oe_n, 1'b0);
      cyc(brap_pkg::PWRUP_CYC + HOLD - 15);
      pin(oe_n, 1'b0);
      cyc(30);
      pin(oe_n, 1'b1);
      pin(lrst_n, 1'b1);
      // Random panel inputs, checked by the monitor
      repeat (40) begin
         @(posedge clk_i);
         seed = lfsr(seed);
         bf_n <= seed[0];
         pwr <= seed[1];
         jmp <= seed[2];
         role <= seed[3];
      end
      // Software abort path, mask and clear
      wr_reg(A_ST, 8'hff);
      role <= 1'b0;
      wr_reg(A_CTL, 8'h04);
      rd_reg(A_CTL, 8'h04);
      wr_reg(A_CTL, 8'h0c);
      cyc(2);
      pin(abt_n, 1'b0);
      pin(irq, 1'b0);
      rd_reg(A_ST, 8'h01);
      wr_reg(A_MSK, 8'h01);
      wr_reg(4'h9, 8'hff);
      rd_reg(4'h9, 8'h00);
      rd_reg(A_MSK, 8'h01);
      rd_reg(A_CTL, 8'h04);
      pin(irq, 1'b1);
      wr_reg(A_ST, 8'h01);
      cyc(2);
      pin(abt_n, 1'b1);
      pin(irq, 1'b0);
      wr_reg(A_CTL, 8'h00);
      wr_reg(A_CTL, 8'h08);
      cyc(3);
      pin(abt_n, 1'b1);
      // Switch bounces shorter than the stable span are ignored
      wr_reg(A_CTL, 8'h04);
      repeat (3) begin
         abt_sw_n <= 1'b0;
         cyc(2);
         abt_sw_n <= 1'b1;
         cyc(2);
      end
      pin(abt_n, 1'b1);
      abt_sw_n <= 1'b0;
      cyc(STAB + 6);
      pin(abt_n, 1'b0);
      pin(abt_pb, 1'b1);
      pin(irq, 1'b1);
      rd_reg(A_ST, 8'h01);
      wr_reg(A_ST, 8'h01);
      cyc(20);
      pin(abt_n, 1'b1);
      abt_sw_n <= 1'b1;
      cyc(STAB + 6);
      pin(abt_pb, 1'b0);
      // Software local reset hold
      wr_reg(A_CTL, 8'h02);
      cyc(50);
      pin(lrst_n, 1'b0);
      pin(leds === 6'h3f, 1'b1);
      // Status: bank from the jumper, only local reset flagged
      rd_reg(brap_pkg::ADDR_STATUS, {2'h0, jmp, 5'h01});
      wr_reg(A_CTL, 8'h00);
      cyc(3);
      pin(lrst_n, 1'b1);
      // Software backplane reset, then watchdog
      role <= 1'b1;
      wr_reg(A_CTL, 8'h01);
      wr_reg(A_CTL, 8'h00);
      cyc(HOLD - 5);
      pin(oe_n, 1'b0);
      pin(lrst_n, 1'b0);
      cyc(15);
      pin(oe_n, 1'b1);
      wdog <= 1'b1;
      cyc(1);
      wdog <= 1'b0;
      cyc(3);
      pin(oe_n, 1'b0);
      pin(sr_n, 1'b0);
      pin(lrst_n, 1'b0);
      cyc(HOLD + 10);
      pin(oe_n, 1'b1);
      pin(lrst_n, 1'b1);
      // Halt lamp latches until the push switch resets the board
      halt <= 1'b1;
      cyc(1);
      halt <= 1'b0;
      cyc(3);
      pin(leds.checkstop, 1'b1);
      rst_sw_n <= 1'b0;
      cyc(3);
      pin(lrst_n, 1'b0);
      pin(oe_n, 1'b0);
      pin(leds === 6'h3f, 1'b1);
      rst_sw_n <= 1'b1;
      cyc(HOLD + 10);
      pin(leds.checkstop, 1'b0);
      pin(oe_n, 1'b1);
      role <= 1'b0;
      cyc(2);
      rst_sw_n <= 1'b0;
      cyc(3);
      pin(lrst_n, 1'b0);
      pin(oe_n, 1'b1);
      rst_sw_n <= 1'b1;
      cyc(5);
      pin(lrst_n, 1'b1);
      // Another controller pulls the backplane reset
      bp_req <= 1'b1;
      cyc(1);
      bp_req <= 1'b0;
      cyc(4);
      pin(lrst_n, 1'b0);
      cyc(PHOLD + 5);
      pin(lrst_n, 1'b1);
      give_verdict();
   end
endmodule
`default_nettype wire
